// file: shared/sdb_consts.vh
/*
 * Constants of the quad-bank burst memory core: geometry, command codes,
 * burst length codes and timing counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef SDB_CONSTS_VH
`define SDB_CONSTS_VH

// geometry
`define SDB_BANKS          4
`define SDB_ROW_W          11
`define SDB_COL_W          8
`define SDB_DATA_W         32
`define SDB_IDX_W          21
`define SDB_WORDS          2097152
`define SDB_FULL_PAGE      9'h100

// commands on {csN, rasN, casN, weN}
`define SDB_CMD_ACTIVE     4'h3
`define SDB_CMD_READ       4'h5
`define SDB_CMD_WRITE      4'h4
`define SDB_CMD_TERMINATE  4'h6
`define SDB_CMD_PRECHARGE  4'h2
`define SDB_CMD_REFRESH    4'h1

// address bit that asks for auto precharge or precharge of all banks
`define SDB_AP_BIT         10

// burst word count codes
`define SDB_BL_1           3'h0
`define SDB_BL_2           3'h1
`define SDB_BL_4           3'h2
`define SDB_BL_8           3'h3
`define SDB_BL_PAGE        3'h7

// self-timed precharge, in link clock edges
`define SDB_PRE_EDGES      2'h2

// internal refresh interval during self refresh
`define SDB_CLK_NS         8
`define SDB_REF_NS         15600
`define SDB_REF_CYC        (`SDB_REF_NS / `SDB_CLK_NS)

`endif

// file: verilog/sdb_in_sync.v
/*
 * Two-flop synchroniser for a group of pins from outside the clock domain.
 * Assumes every bit is a level that stays put for several clk periods.
 */
`timescale 1ns/1ps
`default_nettype none

module sdb_in_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_b,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q_q
);

    reg [W-1:0] meta_q;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_q <= {W{1'b0}};
            q_q    <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q_q    <= meta_q;
        end
    end

endmodule

`default_nettype wire

// file: verilog/sdb_bank_burst_core.v
/*
 * Device side of a quad-bank synchronous burst memory with a 32-bit data path.
 * Pins arrive asynchronously; the link clock is sampled and its rising edges
 * become a one-cycle enable. Read latency and burst word count are plain
 * configuration ports from the clk domain.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sdb_consts.vh"

module sdb_bank_burst_core (
    input  wire        clk,
    input  wire        rst_b,
    input  wire        sdClk,
    input  wire        cke,
    input  wire        csN,
    input  wire        rasN,
    input  wire        casN,
    input  wire        weN,
    input  wire        bankSelectLow,
    input  wire        bankSelectHigh,
    input  wire [10:0] rowColumnAddressLines,
    input  wire [31:0] dqIn,
    input  wire [1:0]  readLatencyCycles,
    input  wire [2:0]  burstWordCount,
    output reg  [31:0] dqOut_q,
    output reg         dqOe_q,
    output reg  [3:0]  bankOpen_q,
    output reg         powerDownActive_q,
    output reg         selfRefreshActive_q,
    output reg  [10:0] refreshRow_q
);

    function [8:0] burstLen;
        input [2:0] code;
        begin
            case (code)
                `SDB_BL_1:    burstLen = 9'h001;
                `SDB_BL_2:    burstLen = 9'h002;
                `SDB_BL_4:    burstLen = 9'h004;
                `SDB_BL_8:    burstLen = 9'h008;
                `SDB_BL_PAGE: burstLen = `SDB_FULL_PAGE;
                default:      burstLen = 9'h001;
            endcase
        end
    endfunction

    function [20:0] memIndex;
        input [1:0]  bank;
        input [10:0] row;
        input [7:0]  col;
        begin
            memIndex = {bank, row, col};
        end
    endfunction

    wire [50:0] syncOut;

    sdb_in_sync #(
        .W (51)
    ) uSync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     ({sdClk, cke, csN, rasN, casN, weN, bankSelectHigh, bankSelectLow,
                 rowColumnAddressLines, dqIn}),
        .q_q   (syncOut)
    );

    wire        sClk  = syncOut[50];
    wire        sCke  = syncOut[49];
    wire [3:0]  sCmd  = syncOut[48:45];
    wire [1:0]  sBank = syncOut[44:43];
    wire [10:0] sAddr = syncOut[42:32];
    wire [31:0] sDq   = syncOut[31:0];

    reg         clkDly_q;
    wire        sdEdge = sClk & ~clkDly_q;

    reg [31:0]  mem [0:`SDB_WORDS-1];
    reg [10:0]  openRow_q [0:3];
    reg [1:0]   preCnt_q [0:3];

    reg         burstAct_q;
    reg         burstWr_q;
    reg         burstAp_q;
    reg [1:0]   burstBank_q;
    reg [7:0]   burstCol_q;
    reg [8:0]   burstLeft_q;

    reg [31:0]  pipe0_q;
    reg [31:0]  pipe1_q;
    reg [2:0]   pipeV_q;
    reg [10:0]  srTimer_q;

    // read and write decode only when awake and cke high
    wire awake   = ~powerDownActive_q & ~selfRefreshActive_q & sCke;
    wire isRw    = awake & ((sCmd == `SDB_CMD_READ) | (sCmd == `SDB_CMD_WRITE));
    wire newRw   = isRw & bankOpen_q[sBank];

    reg         accValid;
    reg         accWr;
    reg         accAp;
    reg [1:0]   accBank;
    reg [7:0]   accCol;
    reg [8:0]   accLeft;

    always @* begin
        if (newRw) begin
            accValid = 1'b1;
            accWr    = (sCmd == `SDB_CMD_WRITE);
            accAp    = sAddr[`SDB_AP_BIT];
            accBank  = sBank;
            accCol   = sAddr[7:0];
            accLeft  = burstLen(burstWordCount);
        end else begin
            accValid = burstAct_q & awake;
            accWr    = burstWr_q;
            accAp    = burstAp_q;
            accBank  = burstBank_q;
            accCol   = burstCol_q;
            accLeft  = burstLeft_q;
        end
    end

    wire [20:0] accIdx  = memIndex(accBank, openRow_q[accBank], accCol);
    wire        accRead = accValid & ~accWr;
    wire [31:0] rdWord  = mem[accIdx];

    // burst data store, on each link rising edge that carries a write word
    always @(posedge clk) begin
        if (sdEdge && accValid && accWr) begin
            mem[accIdx] <= sDq;
        end
    end

    integer i;

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            clkDly_q            <= 1'b0;
            dqOut_q             <= 32'h00000000;
            dqOe_q              <= 1'b0;
            bankOpen_q          <= 4'h0;
            powerDownActive_q   <= 1'b0;
            selfRefreshActive_q <= 1'b0;
            refreshRow_q        <= 11'h000;
            burstAct_q          <= 1'b0;
            burstWr_q           <= 1'b0;
            burstAp_q           <= 1'b0;
            burstBank_q         <= 2'h0;
            burstCol_q          <= 8'h00;
            burstLeft_q         <= 9'h000;
            pipe0_q             <= 32'h00000000;
            pipe1_q             <= 32'h00000000;
            pipeV_q             <= 3'h0;
            srTimer_q           <= 11'h000;
            for (i = 0; i < 4; i = i + 1) begin
                openRow_q[i] <= 11'h000;
                preCnt_q[i]  <= 2'h0;
            end
        end else begin
            clkDly_q <= sClk;

            // internal refresh timer while in self refresh
            if (selfRefreshActive_q) begin
                if ({21'h000000, srTimer_q} == `SDB_REF_CYC - 1) begin
                    srTimer_q    <= 11'h000;
                    refreshRow_q <= refreshRow_q + 11'h001;
                end else begin
                    srTimer_q <= srTimer_q + 11'h001;
                end
            end else begin
                srTimer_q <= 11'h000;
            end

            if (sdEdge) begin
                // each bank counts down its own precharge
                for (i = 0; i < 4; i = i + 1) begin
                    if (preCnt_q[i] != 2'h0) begin
                        preCnt_q[i] <= preCnt_q[i] - 2'h1;
                    end
                end

                // read pipeline and output select
                pipe0_q <= rdWord;
                pipe1_q <= pipe0_q;
                if (accValid && accWr) begin
                    pipeV_q <= 3'h0;
                    dqOe_q  <= 1'b0;
                end else begin
                    pipeV_q <= {pipeV_q[1:0], accRead};
                    if (readLatencyCycles == 2'h3) begin
                        dqOut_q <= pipe1_q;
                        dqOe_q  <= pipeV_q[1];
                    end else if (readLatencyCycles == 2'h2) begin
                        dqOut_q <= pipe0_q;
                        dqOe_q  <= pipeV_q[0];
                    end else begin
                        dqOut_q <= rdWord;
                        dqOe_q  <= accRead;
                    end
                end

                // interrupted burst still owes its auto precharge
                if (newRw && burstAct_q && burstAp_q) begin
                    bankOpen_q[burstBank_q] <= 1'b0;
                    preCnt_q[burstBank_q]   <= `SDB_PRE_EDGES;
                end

                // burst advance with internal column generation
                if (accValid) begin
                    burstBank_q <= accBank;
                    burstWr_q   <= accWr;
                    burstAp_q   <= accAp;
                    burstCol_q  <= accCol + 8'h01;
                    burstLeft_q <= accLeft - 9'h001;
                    burstAct_q  <= (accLeft != 9'h001);
                    if (accLeft == 9'h001 && accAp) begin
                        bankOpen_q[accBank] <= 1'b0;
                        preCnt_q[accBank]   <= `SDB_PRE_EDGES;
                    end
                end

                if (selfRefreshActive_q) begin
                    if (sCke) begin
                        selfRefreshActive_q <= 1'b0;
                    end
                end else if (powerDownActive_q) begin
                    if (sCke) begin
                        powerDownActive_q <= 1'b0;
                    end
                end else if (!sCke) begin
                    if (sCmd == `SDB_CMD_REFRESH) begin
                        selfRefreshActive_q <= 1'b1;
                        burstAct_q          <= 1'b0;
                    end else if (!burstAct_q) begin
                        powerDownActive_q <= 1'b1;
                    end
                end else begin
                    case (sCmd)
                        `SDB_CMD_ACTIVE: begin
                            if (!bankOpen_q[sBank] && preCnt_q[sBank] == 2'h0) begin
                                bankOpen_q[sBank] <= 1'b1;
                                openRow_q[sBank]  <= sAddr;
                            end
                        end
                        `SDB_CMD_TERMINATE: begin
                            burstAct_q <= 1'b0;
                        end
                        `SDB_CMD_PRECHARGE: begin
                            if (sAddr[`SDB_AP_BIT]) begin
                                for (i = 0; i < 4; i = i + 1) begin
                                    if (bankOpen_q[i]) begin
                                        bankOpen_q[i] <= 1'b0;
                                        preCnt_q[i]   <= `SDB_PRE_EDGES;
                                    end
                                end
                            end else if (bankOpen_q[sBank]) begin
                                bankOpen_q[sBank] <= 1'b0;
                                preCnt_q[sBank]   <= `SDB_PRE_EDGES;
                            end
                        end
                        `SDB_CMD_REFRESH: begin
                            refreshRow_q <= refreshRow_q + 11'h001;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end
    end

endmodule

`default_nettype wire

// file: bench/sdb_ctrl_model.sv
/* Controller model: link clock, command pins and write data.
   Assumes clk of 8 ns; one link period is 20 clk. */
`timescale 1ns/1ps
`default_nettype none
module sdb_ctrl_model (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [31:0] dqOut_q,
    input  wire logic        dqOe_q,
    output var  logic        sdClk,
    output var  logic        cke,
    output var  logic [3:0]  cmd,
    output var  logic [1:0]  bank,
    output var  logic [10:0] addr,
    output var  logic [31:0] dqIn
);
    logic [4:0] ph_q;
    initial begin
        sdClk = 1'b0;
        cke = 1'b1;
        cmd = 4'h7;
        bank = 2'h0;
        addr = 11'h000;
        dqIn = 32'h0;
    end
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ph_q <= 5'h00;
            sdClk <= 1'b0;
        end else begin
            ph_q <= (ph_q == 5'h13) ? 5'h00 : ph_q + 5'h01;
            sdClk <= (ph_q >= 5'h09) && (ph_q <= 5'h12);
        end
    end
    // pins move with the link falling edge: 10 clk setup and hold
    task automatic step(input logic k, input logic [3:0] c, input logic [1:0] b,
                        input logic [10:0] a, input logic drv, input logic [31:0] d,
                        output logic [31:0] q, output logic oe);
        do @(posedge clk); while (ph_q != 5'h13);
        cke <= k;
        cmd <= c;
        bank <= b;
        addr <= a;
        dqIn <= drv ? d : ~dqIn;
        do @(posedge clk); while (ph_q != 5'h09);
        q = dqOut_q;
        oe = dqOe_q;
    endtask
endmodule
`default_nettype wire

// file: bench/sdb_core_asserts.sv
/* Checker bound to the burst memory core ports.
   Assumes a link period longer than 8 clk. */
`timescale 1ns/1ps
`default_nettype none
`include "sdb_consts.vh"
module sdb_core_asserts (
    input wire logic        clk,
    input wire logic        rst_b,
    input wire logic        sdClk,
    input wire logic        cke,
    input wire logic        csN,
    input wire logic        rasN,
    input wire logic        casN,
    input wire logic        weN,
    input wire logic [31:0] dqOut_q,
    input wire logic        dqOe_q,
    input wire logic [3:0]  bankOpen_q,
    input wire logic        powerDownActive_q,
    input wire logic        selfRefreshActive_q,
    input wire logic [10:0] refreshRow_q
);
    logic        sdPrev_q;
    logic [3:0]  rise_q;
    logic [11:0] srWait_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            sdPrev_q <= 1'b0;
            rise_q <= 4'hf;
            srWait_q <= 12'h000;
        end else begin
            sdPrev_q <= sdClk;
            rise_q <= (sdClk && !sdPrev_q) ? 4'h0 : rise_q + {3'h0, rise_q != 4'hf};
            srWait_q <= (selfRefreshActive_q && $stable(refreshRow_q)) ?
                        srWait_q + 12'h001 : 12'h000;
        end
    end
    AST_OE_ON_EDGE: assert property (!$stable(dqOe_q) |-> rise_q <= 4'h7)
        else $error("data drive changed away from a link edge");
    AST_DATA_ON_EDGE: assert property (!$stable(dqOut_q) |-> rise_q <= 4'h7)
        else $error("read data changed away from a link edge");
    AST_BANK_ON_EDGE: assert property (!$stable(bankOpen_q) |-> rise_q <= 4'h7)
        else $error("open banks changed away from a link edge");
    AST_OPEN_BY_ACTIVE: assert property ((|(bankOpen_q & ~$past(bankOpen_q)))
        |-> $past({csN, rasN, casN, weN}, 3) == `SDB_CMD_ACTIVE)
        else $error("bank opened without activation");
    AST_MODES_APART: assert property (!(powerDownActive_q && selfRefreshActive_q))
        else $error("power-down and self refresh together");
    AST_ROW_STEP: assert property (!$stable(refreshRow_q)
        |-> refreshRow_q == $past(refreshRow_q) + 11'h001)
        else $error("refresh row skipped");
    AST_SR_INTERVAL: assert property (srWait_q < 12'h7d0)
        else $error("self refresh stalled");
    AST_LOW_ENTRY: assert property (
        $rose(powerDownActive_q) || $rose(selfRefreshActive_q) |-> !$past(cke, 3))
        else $error("low power entered with clock enable high");
    AST_LOW_EXIT: assert property (
        $fell(powerDownActive_q) || $fell(selfRefreshActive_q) |-> $past(cke, 2))
        else $error("low power left with clock enable low");
endmodule
bind sdb_bank_burst_core sdb_core_asserts u_sdb_core_asserts (.clk(clk), .rst_b(rst_b),
    .sdClk(sdClk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
    .dqOut_q(dqOut_q), .dqOe_q(dqOe_q), .bankOpen_q(bankOpen_q),
    .powerDownActive_q(powerDownActive_q), .selfRefreshActive_q(selfRefreshActive_q),
    .refreshRow_q(refreshRow_q));
`default_nettype wire

// file: bench/testbench.sv
/* Self-checking bench for the burst memory core.
   Assumes the controller model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
`include "sdb_consts.vh"
module testbench;
    logic        clk, rst_b, ck, oe, sdClk, cke, dqOe_q, pdAct, srAct;
    logic [1:0]  lat, bank;
    logic [2:0]  bl;
    logic [3:0]  cmd, bankOpen_q;
    logic [10:0] addr, refreshRow_q;
    logic [31:0] q, dqIn, dqOut_q;
    int          failCount = 0, checkCount = 0, cycles = 0;
    sdb_ctrl_model u_sdb_ctrl_model (.clk(clk), .rst_b(rst_b), .dqOut_q(dqOut_q),
        .dqOe_q(dqOe_q), .sdClk(sdClk), .cke(cke), .cmd(cmd), .bank(bank), .addr(addr),
        .dqIn(dqIn));
    sdb_bank_burst_core u_sdb_bank_burst_core (.clk(clk), .rst_b(rst_b), .sdClk(sdClk),
        .cke(cke), .csN(cmd[3]), .rasN(cmd[2]), .casN(cmd[1]), .weN(cmd[0]),
        .bankSelectLow(bank[0]), .bankSelectHigh(bank[1]), .rowColumnAddressLines(addr),
        .dqIn(dqIn), .readLatencyCycles(lat), .burstWordCount(bl), .dqOut_q(dqOut_q),
        .dqOe_q(dqOe_q), .bankOpen_q(bankOpen_q), .powerDownActive_q(pdAct),
        .selfRefreshActive_q(srAct), .refreshRow_q(refreshRow_q));
    function automatic logic [31:0] pat(input logic [1:0] b, input logic [7:0] c);
        return {8'ha5, 6'h00, b, 8'h3c, c};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp) begin
            failCount++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic go(input logic [3:0] c, input logic [1:0] b, input logic [10:0] a,
                      input logic drv, input logic [31:0] d);
        u_sdb_ctrl_model.step(ck, c, b, a, drv, d, q, oe);
    endtask
    task automatic nop(input int n);
        repeat (n) go(4'h7, 2'h0, 11'h000, 1'b0, 32'h0);
    endtask
    task automatic wrBurst(input logic [1:0] b, input logic [7:0] c, input int n,
                           input logic ap);
        go(`SDB_CMD_WRITE, b, {ap, 2'h0, c}, 1'b1, pat(b, c));
        for (int i = 1; i < n; i++)
            go(4'h7, b, 11'h000, 1'b1, pat(b, c + 8'(i)));
    endtask
    task automatic rdBurst(input logic [1:0] b, input logic [7:0] c, input int n,
                           input int cl, input logic ap);
        lat <= 2'(cl);
        go(`SDB_CMD_READ, b, {ap, 2'h0, c}, 1'b0, 32'h0);
        for (int i = 1; i <= cl + n; i++) begin
            nop(1);
            if (i < cl || i == cl + n) begin
                chk({31'h0, oe}, 32'h0);
            end else begin
                chk(q, pat(b, c + 8'(i - cl)));
                chk({31'h0, oe}, 32'h1);
            end
        end
    endtask
    task automatic endOfTest();
        if (failCount == 0 && checkCount > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failCount++;
            endOfTest();
        end
    end
    initial begin
        rst_b = 1'b0;
        ck = 1'b1;
        lat = 2'h1;
        bl = `SDB_BL_8;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        chk({15'h0, bankOpen_q, pdAct, srAct, refreshRow_q}, 32'h0);
        for (int b = 0; b < 4; b++)
            go(`SDB_CMD_ACTIVE, 2'(b), 11'h7ff, 1'b0, 32'h0);
        nop(1);
        chk({28'h0, bankOpen_q}, 32'hf);
        for (int b = 0; b < 4; b++)
            wrBurst(2'(b), 8'hfc, 8, 1'b0);
        bl <= `SDB_BL_4;
        for (int cl = 1; cl < 4; cl++)
            rdBurst(2'(cl), 8'hfe, 4, cl, 1'b0);
        bl <= `SDB_BL_PAGE;
        lat <= 2'h2;
        go(`SDB_CMD_READ, 2'h0, 11'h0ff, 1'b0, 32'h0);
        go(`SDB_CMD_READ, 2'h0, 11'h0fe, 1'b0, 32'h0);
        for (int i = 0; i < 5; i++) begin
            nop(1);
            chk(q, pat(2'h0, i == 0 ? 8'hff : 8'hfd + 8'(i)));
        end
        go(`SDB_CMD_TERMINATE, 2'h0, 11'h000, 1'b0, 32'h0);
        nop(3);
        chk({31'h0, oe}, 32'h0);
        bl <= `SDB_BL_2;
        wrBurst(2'h1, 8'h10, 2, 1'b1);
        go(`SDB_CMD_PRECHARGE, 2'h3, 11'h000, 1'b0, 32'h0);
        rdBurst(2'h2, 8'h02, 2, 1, 1'b0);
        chk({28'h0, bankOpen_q}, 32'h5);
        go(`SDB_CMD_ACTIVE, 2'h1, 11'h7ff, 1'b0, 32'h0);
        nop(1);
        bl <= `SDB_BL_1;
        rdBurst(2'h1, 8'h11, 1, 3, 1'b1);
        chk({28'h0, bankOpen_q}, 32'h5);
        go(`SDB_CMD_PRECHARGE, 2'h0, 11'h400, 1'b0, 32'h0);
        nop(2);
        chk({28'h0, bankOpen_q}, 32'h0);
        go(`SDB_CMD_REFRESH, 2'h0, 11'h000, 1'b0, 32'h0);
        nop(1);
        chk({21'h0, refreshRow_q}, 32'h1);
        ck = 1'b0;
        nop(2);
        chk({31'h0, pdAct}, 32'h1);
        ck = 1'b1;
        nop(2);
        chk({31'h0, pdAct}, 32'h0);
        ck = 1'b0;
        go(`SDB_CMD_REFRESH, 2'h0, 11'h000, 1'b0, 32'h0);
        nop(1);
        chk({31'h0, srAct}, 32'h1);
        nop(104);
        chk({21'h0, refreshRow_q}, 32'h2);
        ck = 1'b1;
        nop(2);
        chk({31'h0, srAct}, 32'h0);
        endOfTest();
    end
endmodule
`default_nettype wire
